// [hdl/rcal_core.sv]
// Implementation choices: the address map and the strobed register port.
`include "rcal_defines.svh"

module rcal_core
  import rcal_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        sys_rst,
  input  wire logic        sys_unlock,
  input  wire logic        ext_osc,
  input  wire logic        int_osc,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  rcal_time_t       alarm_time,
  input  wire logic        alarm_date_hit,
  output logic             rtc_pin,
  output logic             rtc_pin_oe,
  output logic             alarm_evt
);
  rcal_tick_if tk ();

  logic        on_ff;
  logic [1:0]  sel_ff;
  logic [1:0]  osel_ff;
  logic        oe_ff;
  logic        wren_ff;
  logic [9:0]  cal_ff;
  logic        aon_ff;
  logic        chime_ff;
  logic        pulse_ff;
  logic [3:0]  mask_ff;
  logic [7:0]  rpt_ff;
  logic [31:0] rdata_ff;
  logic        pin_ff;
  logic        pin_oe_ff;
  logic        evt_ff;
  logic        half_d_ff;
  logic        sec_d_ff;
  logic        wr_ctrl;
  logic        wr_alrm;
  logic        wr_time;
  logic        time_ld;
  logic        vsync;
  logic        hit;
  logic        evt;
  logic        m_s1;
  logic        m_s;
  logic        m_m1;
  logic        m_m;
  logic        m_h;
  logic        pin_sel;
  logic [31:0] rd_mux;
  rcal_time_t  time_q;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  rcal_prescaler u_pre (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .ext_osc  (ext_osc),
    .int_osc  (int_osc),
    .on       (on_ff),
    .src_sel  (sel_ff),
    .cal      (cal_ff),
    .tk       (tk.pre)
  );

  rcal_timecount u_time (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .tk       (tk.cnt),
    .ld       (time_ld),
    .ld_time  (rcal_time_t'(wdata[31:8])),
    .time_q   (time_q)
  );

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign wr_ctrl = wr && addr == `RCAL_OFS_CTRL;
  assign wr_alrm = wr && addr == `RCAL_OFS_ALRM;
  assign wr_time = wr && addr == `RCAL_OFS_TIME;
  assign time_ld = wr_time & wren_ff;
  assign tk.restart = time_ld;
  assign vsync = tk.near_half & tk.half_flag;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // only power-on reset clears these; sys_rst does not
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_ff <= 1'b0;
      sel_ff <= `RCAL_SRC_INT;
      osel_ff <= `RCAL_OUT_ALRM;
      oe_ff <= 1'b0;
      wren_ff <= 1'b0;
      cal_ff <= `RCAL_CAL_RST;
    end else if (ce && wr_ctrl) begin
      cal_ff <= wdata[`RCAL_C_CAL_HI:`RCAL_C_CAL_LO];
      sel_ff <= wdata[`RCAL_C_SEL_HI:`RCAL_C_SEL_LO];
      osel_ff <= wdata[`RCAL_C_OSEL_HI:`RCAL_C_OSEL_LO];
      oe_ff <= wdata[`RCAL_C_OE];
      // unlock needs system sequence to set
      wren_ff <= wdata[`RCAL_C_WREN] & (wren_ff | sys_unlock);
      if (wren_ff) begin
        on_ff <= wdata[`RCAL_C_ON];
      end
    end
  end

  // ----------------------------------------
  // alarm match
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_d_ff <= 1'b0;
      sec_d_ff <= 1'b0;
    end else if (ce) begin
      half_d_ff <= tk.half_tick;
      sec_d_ff <= tk.sec_tick;
    end
  end

  // compare one cycle after the tick, once the time has advanced
  assign m_s1 = time_q.sec_o == alarm_time.sec_o;
  assign m_s = m_s1 && time_q.sec_t == alarm_time.sec_t;
  assign m_m1 = m_s && time_q.min_o == alarm_time.min_o;
  assign m_m = m_m1 && time_q.min_t == alarm_time.min_t;
  assign m_h = m_m && time_q.hr_o == alarm_time.hr_o && time_q.hr_t == alarm_time.hr_t;

  always_comb begin
    case (mask_ff)
      `RCAL_IV_HALF:  hit = half_d_ff;
      `RCAL_IV_SEC:   hit = sec_d_ff;
      `RCAL_IV_10S:   hit = sec_d_ff & m_s1;
      `RCAL_IV_MIN:   hit = sec_d_ff & m_s;
      `RCAL_IV_10M:   hit = sec_d_ff & m_m1;
      `RCAL_IV_HOUR:  hit = sec_d_ff & m_m;
      `RCAL_IV_DAY:   hit = sec_d_ff & m_h;
      `RCAL_IV_WEEK,
      `RCAL_IV_MONTH,
      `RCAL_IV_YEAR:  hit = sec_d_ff & m_h & alarm_date_hit;
      default:        hit = 1'b0;
    endcase
  end

  assign evt = on_ff & aon_ff & hit;

  // ----------------------------------------
  // alarm control register
  // ----------------------------------------
  // software write wins over an event in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aon_ff <= 1'b0;
      chime_ff <= 1'b0;
      pulse_ff <= 1'b0;
      mask_ff <= `RCAL_IV_HALF;
      rpt_ff <= `RCAL_RPT_RST;
    end else if (ce) begin
      if (wr_alrm) begin
        aon_ff <= wdata[`RCAL_A_ON];
        chime_ff <= wdata[`RCAL_A_CHIME];
        mask_ff <= wdata[`RCAL_A_MASK_HI:`RCAL_A_MASK_LO];
        rpt_ff <= wdata[`RCAL_A_RPT_HI:`RCAL_A_RPT_LO];
        // initial level only while alarm off
        if (!aon_ff) begin
          pulse_ff <= wdata[`RCAL_A_PIV];
        end
      end else if (evt) begin
        pulse_ff <= ~pulse_ff;
        if (rpt_ff != 8'h00) begin
          rpt_ff <= rpt_ff - 8'h01;
        end else if (chime_ff) begin
          rpt_ff <= 8'hff;
        end else begin
          aon_ff <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr)
      `RCAL_OFS_CTRL: begin
        rd_mux[`RCAL_C_CAL_HI:`RCAL_C_CAL_LO] = cal_ff;
        rd_mux[`RCAL_C_ON] = on_ff;
        rd_mux[`RCAL_C_SEL_HI:`RCAL_C_SEL_LO] = sel_ff;
        rd_mux[`RCAL_C_OSEL_HI:`RCAL_C_OSEL_LO] = osel_ff;
        rd_mux[`RCAL_C_RUN] = tk.running;
        rd_mux[`RCAL_C_WREN] = wren_ff;
        rd_mux[`RCAL_C_VSYNC] = vsync;
        rd_mux[`RCAL_C_HALF] = tk.half_flag;
        rd_mux[`RCAL_C_OE] = oe_ff;
      end
      `RCAL_OFS_ALRM: begin
        rd_mux[`RCAL_A_ON] = aon_ff;
        rd_mux[`RCAL_A_CHIME] = chime_ff;
        rd_mux[`RCAL_A_PIV] = pulse_ff;
        rd_mux[`RCAL_A_SYNC] = tk.near_half;
        rd_mux[`RCAL_A_MASK_HI:`RCAL_A_MASK_LO] = mask_ff;
        rd_mux[`RCAL_A_RPT_HI:`RCAL_A_RPT_LO] = rpt_ff;
      end
      `RCAL_OFS_TIME: rd_mux = {time_q, 8'h00};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // data only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (ce) begin
      rdata_ff <= (rd && !sys_rst) ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // pin output
  // ----------------------------------------
  // output select
  always_comb begin
    case (osel_ff)
      `RCAL_OUT_CLK:  pin_sel = tk.tk_lvl;
      `RCAL_OUT_SEC:  pin_sel = tk.half_flag;
      `RCAL_OUT_ALRM: pin_sel = pulse_ff;
      default:        pin_sel = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      evt_ff <= 1'b0;
    end else if (ce) begin
      pin_ff <= oe_ff & pin_sel;
      pin_oe_ff <= oe_ff;
      evt_ff <= evt & ~sys_rst;
    end
  end

  assign rdata = rdata_ff;
  assign rtc_pin = pin_ff;
  assign rtc_pin_oe = pin_oe_ff;
  assign alarm_evt = evt_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk iff ce); endclocking
  default disable iff (!arst_n);

  sequence s_time_wr;
    wr_time && wren_ff;
  endsequence

  sequence s_event(logic z, logic c);
    evt && !wr_alrm && (rpt_ff == 8'h00) == z && chime_ff == c;
  endsequence

  a_on_locked: assert property (wr_ctrl && !wren_ff |=> $stable(on_ff))
    else $error("on bit changed while locked");
  a_time_locked: assert property (wr_time && !wren_ff && !tk.sec_tick |=>
      $stable(time_q))
    else $error("time changed by locked write");
  a_unlock_seq: assert property (wr_ctrl && wdata[`RCAL_C_WREN] && !wren_ff &&
      !sys_unlock |=> !wren_ff)
    else $error("unlock set without system sequence");
  a_half_clear: assert property (s_time_wr |=> !tk.half_flag ##1 !tk.half_flag)
    else $error("half flag not cleared by seconds write");
  a_pin_idle: assert property (!oe_ff |=> !rtc_pin && !rtc_pin_oe)
    else $error("pin active while disabled");
  a_pin_clock: assert property (oe_ff && osel_ff == `RCAL_OUT_CLK |=>
      rtc_pin == $past(tk.tk_lvl))
    else $error("pin does not follow clock");
  a_rpt_down: assert property (s_event(1'b0, chime_ff) |=>
      rpt_ff == $past(rpt_ff) - 8'h01 && aon_ff)
    else $error("repeat count not decremented");
  a_chime_wrap: assert property (s_event(1'b1, 1'b1) |=> rpt_ff == 8'hff && aon_ff)
    else $error("chime did not wrap repeat count");
  a_alarm_stop: assert property (s_event(1'b1, 1'b0) |=> !aon_ff ##1 !evt)
    else $error("alarm not disabled after last event");
  a_piv_ro: assert property (wr_alrm && aon_ff |=> $stable(pulse_ff))
    else $error("pulse level written while alarm on");
  a_alrm_sync: assert property (rd && addr == `RCAL_OFS_ALRM && !sys_rst |=>
      rdata[`RCAL_A_SYNC] == $past(tk.near_half))
    else $error("alarm unstable flag misreported");
  a_ctrl_keep: assert property (sys_rst && !wr_ctrl |=>
      $stable({on_ff, sel_ff, osel_ff, oe_ff, wren_ff, cal_ff}))
    else $error("control lost on non power-on reset");
endmodule

// [hdl/rcal_defines.svh]
`ifndef RCAL_DEFINES_SVH
`define RCAL_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RCAL_OFS_CTRL    8'h00
`define RCAL_OFS_ALRM    8'h04
`define RCAL_OFS_TIME    8'h08

// ----------------------------------------
// control fields
// ----------------------------------------
`define RCAL_C_CAL_HI    25
`define RCAL_C_CAL_LO    16
`define RCAL_C_ON        15
`define RCAL_C_SEL_HI    10
`define RCAL_C_SEL_LO    9
`define RCAL_C_OSEL_HI   8
`define RCAL_C_OSEL_LO   7
`define RCAL_C_RUN       6
`define RCAL_C_WREN      3
`define RCAL_C_VSYNC     2
`define RCAL_C_HALF      1
`define RCAL_C_OE        0

// ----------------------------------------
// alarm control fields
// ----------------------------------------
`define RCAL_A_ON        15
`define RCAL_A_CHIME     14
`define RCAL_A_PIV       13
`define RCAL_A_SYNC      12
`define RCAL_A_MASK_HI   11
`define RCAL_A_MASK_LO   8
`define RCAL_A_RPT_HI    7
`define RCAL_A_RPT_LO    0

// ----------------------------------------
// codes
// ----------------------------------------
`define RCAL_SRC_INT     2'h0
`define RCAL_SRC_EXT     2'h1
`define RCAL_OUT_ALRM    2'h0
`define RCAL_OUT_SEC     2'h1
`define RCAL_OUT_CLK     2'h2
`define RCAL_IV_HALF     4'h0
`define RCAL_IV_SEC      4'h1
`define RCAL_IV_10S      4'h2
`define RCAL_IV_MIN      4'h3
`define RCAL_IV_10M      4'h4
`define RCAL_IV_HOUR     4'h5
`define RCAL_IV_DAY      4'h6
`define RCAL_IV_WEEK     4'h7
`define RCAL_IV_MONTH    4'h8
`define RCAL_IV_YEAR     4'h9

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RCAL_CAL_RST     10'h000
`define RCAL_RPT_RST     8'h00
`define RCAL_TIME_RST    24'h000000
`define RCAL_DIG_LIM     16'h5959
`define RCAL_HR_LAST     8'h23
`define RCAL_PRE_HALF    14'h3fff
`define RCAL_SYNC_GUARD  32
`define RCAL_CLK_NS      10
`define RCAL_TK_STALL_NS 40000
`define RCAL_TK_STALL_CYC (`RCAL_TK_STALL_NS / `RCAL_CLK_NS)

`endif

// [hdl/rcal_pkg.sv]
package rcal_pkg;
  typedef logic [3:0] rcal_bcd_t;
  typedef struct packed {
    rcal_bcd_t hr_t;
    rcal_bcd_t hr_o;
    rcal_bcd_t min_t;
    rcal_bcd_t min_o;
    rcal_bcd_t sec_t;
    rcal_bcd_t sec_o;
  } rcal_time_t;
endpackage

// [hdl/rcal_prescaler.sv]
`include "rcal_defines.svh"

module rcal_prescaler
  import rcal_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       ext_osc,
  input  wire logic       int_osc,
  input  wire logic       on,
  input  wire logic [1:0] src_sel,
  input  wire logic [9:0] cal,
  rcal_tick_if.pre        tk
);
  localparam logic [12:0] STALL = 13'(`RCAL_TK_STALL_CYC);

  logic [1:0]  s1_ff;
  logic [1:0]  s2_ff;
  logic        lvl;
  logic        lvl_d_ff;
  logic        osc_edge;
  logic        edge_w;
  logic        roll_w;
  logic [14:0] cnt_ff;
  logic [9:0]  skip_ff;
  logic [12:0] idle_ff;
  logic        half_ff;
  logic        sec_ff;
  logic        run_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
      lvl_d_ff <= 1'b0;
    end else if (ce) begin
      s1_ff <= {ext_osc, int_osc};
      s2_ff <= s1_ff;
      lvl_d_ff <= lvl;
    end
  end

  always_comb begin
    case (src_sel)
      `RCAL_SRC_INT: lvl = s2_ff[0];
      `RCAL_SRC_EXT: lvl = s2_ff[1];
      default:       lvl = 1'b0;
    endcase
  end

  assign osc_edge = lvl & ~lvl_d_ff;
  assign edge_w = on & osc_edge;
  assign roll_w = edge_w & (skip_ff == 10'h000) & (cnt_ff[13:0] == `RCAL_PRE_HALF);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 15'h0000;
      skip_ff <= 10'h000;
    end else if (ce) begin
      if (tk.restart) begin
        cnt_ff <= 15'h0000;
        skip_ff <= 10'h000;
      end else if (on && tk.min_tick && cal != 10'h000) begin
        if (cal[9]) begin
          skip_ff <= 10'h000 - cal;
        end else begin
          cnt_ff <= cnt_ff + {6'h00, cal[8:0]};
        end
      end else if (edge_w) begin
        if (skip_ff != 10'h000) begin
          skip_ff <= skip_ff - 10'h001;
        end else begin
          cnt_ff <= cnt_ff + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_ff <= STALL;
      run_ff <= 1'b0;
      half_ff <= 1'b0;
      sec_ff <= 1'b0;
    end else if (ce) begin
      if (osc_edge) begin
        idle_ff <= 13'h0000;
      end else if (idle_ff != STALL) begin
        idle_ff <= idle_ff + 13'h0001;
      end
      run_ff <= on & (idle_ff != STALL);
      half_ff <= roll_w;
      sec_ff <= roll_w & cnt_ff[14];
    end
  end

  assign tk.half_tick = half_ff;
  assign tk.sec_tick = sec_ff;
  assign tk.running = run_ff;
  assign tk.tk_lvl = lvl_d_ff;
  assign tk.half_flag = cnt_ff[14];
  assign tk.near_half = cnt_ff[13:0] > (`RCAL_PRE_HALF - 14'(`RCAL_SYNC_GUARD));

  default clocking cb @(posedge core_clk iff ce); endclocking
  default disable iff (!arst_n);

  a_sec_phase: assert property (tk.sec_tick && !tk.restart |-> !tk.half_flag)
    else $error("second tick while in second half");
  a_run_off: assert property (!on |=> !tk.running)
    else $error("running flag set while module off");
endmodule

// [hdl/rcal_tick_if.sv]
interface rcal_tick_if;
  logic half_tick;
  logic sec_tick;
  logic half_flag;
  logic near_half;
  logic tk_lvl;
  logic running;
  logic min_tick;
  logic restart;
  modport pre (output half_tick, sec_tick, half_flag, near_half, tk_lvl, running,
               input min_tick, restart);
  modport cnt (input sec_tick, output min_tick);
  modport top (input half_tick, sec_tick, half_flag, near_half, tk_lvl, running, min_tick,
               output restart);
endinterface

// [hdl/rcal_timecount.sv]
`include "rcal_defines.svh"

module rcal_timecount
  import rcal_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic ce,
  rcal_tick_if.cnt  tk,
  input  wire logic ld,
  input  rcal_time_t ld_time,
  output rcal_time_t time_q
);
  rcal_time_t  time_ff;
  logic [15:0] lo_w;
  logic [15:0] nxt_lo;
  logic [7:0]  nxt_hr;
  logic [4:0]  cy;
  logic        min_ff;

  assign lo_w = {time_ff.min_t, time_ff.min_o, time_ff.sec_t, time_ff.sec_o};
  assign cy[0] = tk.sec_tick;

  for (genvar i = 0; i < 4; i++) begin : g_dig
    localparam logic [15:0] DIG_LIM = `RCAL_DIG_LIM;
    logic at_lim;
    assign at_lim = lo_w[4*i+:4] == DIG_LIM[4*i+:4];
    assign cy[i+1] = cy[i] & at_lim;
    assign nxt_lo[4*i+:4] = !cy[i] ? lo_w[4*i+:4] :
                            (at_lim ? 4'h0 : lo_w[4*i+:4] + 4'h1);
  end

  always_comb begin
    nxt_hr = {time_ff.hr_t, time_ff.hr_o};
    if (cy[4]) begin
      if (nxt_hr == `RCAL_HR_LAST) begin
        nxt_hr = 8'h00;
      end else if (nxt_hr[3:0] == 4'h9) begin
        nxt_hr = {nxt_hr[7:4] + 4'h1, 4'h0};
      end else begin
        nxt_hr[3:0] = nxt_hr[3:0] + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      time_ff <= rcal_time_t'(`RCAL_TIME_RST);
      min_ff <= 1'b0;
    end else if (ce) begin
      if (ld) begin
        time_ff <= ld_time;
      end else if (tk.sec_tick) begin
        time_ff <= rcal_time_t'({nxt_hr, nxt_lo});
      end
      min_ff <= cy[2] & ~ld;
    end
  end

  assign time_q = time_ff;
  assign tk.min_tick = min_ff;

  default clocking cb @(posedge core_clk iff ce); endclocking
  default disable iff (!arst_n);

  a_sec_wrap: assert property (tk.sec_tick && !ld && time_ff.sec_t == 4'h5 &&
      time_ff.sec_o == 4'h9 |=> time_ff.sec_t == 4'h0 && time_ff.sec_o == 4'h0 && min_ff)
    else $error("seconds did not wrap after 59");
endmodule

// [sim/tb.sv]
`include "rcal_defines.svh"

module tb
  import rcal_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk, arst_n, ce, sys_rst, sys_unlock;
  logic        ext_osc, int_osc, ext_en, int_en;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, tv, cv, am;
  logic        wr, rd, rd_pend, alarm_date_hit, rtc_pin, rtc_pin_oe, alarm_evt;
  rcal_time_t  alarm_time;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          n_errors, n_checks;
  int          n_evt = 0;
  int          osc_hp = 45;
  logic [3:0]  ext_h;

  localparam logic [31:0] MC = 32'hffff_fffb;
  localparam logic [31:0] MA = 32'hffff_efff;

  rcal_core dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .sys_rst(sys_rst),
    .sys_unlock(sys_unlock), .ext_osc(ext_osc), .int_osc(int_osc), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alarm_time(alarm_time),
    .alarm_date_hit(alarm_date_hit), .rtc_pin(rtc_pin), .rtc_pin_oe(rtc_pin_oe),
    .alarm_evt(alarm_evt)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // slow oscillators, in a fixed phase to the core clock
  initial begin
    ext_osc = 1'b0;
    int_osc = 1'b0;
    // offset keeps pin changes away from the core clock edges
    #2;
    forever begin
      #(osc_hp);
      if (ext_en) ext_osc = ~ext_osc;
      if (int_en) int_osc = ~int_osc;
    end
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk) rd_pend <= rd;
  // crystal as the core samples it; the pin shows it three edges later
  always @(posedge core_clk) ext_h <= {ext_h[2:0], ext_osc};
  always @(negedge core_clk) begin
    if (alarm_evt === 1'b1) n_evt++;
  end
  always @(negedge core_clk) begin
    if (rd_pend === 1'b1) begin
      chk(rdata, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  initial begin
    #900000;
    n_errors++;
    $display("BAD %0t run too long", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd32(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pin_chk(input logic oe, input logic pin);
    chk({30'h0, rtc_pin_oe, rtc_pin}, {30'h0, oe, pin}, 32'h3);
  endtask

  // the clock on the pin must show both levels within a few periods
  task automatic pin_toggles();
    logic [1:0] seen;
    seen = 2'b00;
    for (int k = 0; k < 300; k++) begin
      @(negedge core_clk);
      if (rtc_pin === 1'b0) seen[0] = 1'b1;
      if (rtc_pin === 1'b1) seen[1] = 1'b1;
    end
    @(posedge core_clk);
    chk({30'h0, seen}, 32'h3, 32'h3);
  endtask

  task automatic evt_wait();
    int k;
    k = 0;
    wr <= 1'b0;
    rd <= 1'b0;
    while (n_evt == 0 && k < 40000) begin
      @(posedge core_clk);
      k++;
    end
    if (n_evt == 0) begin
      n_errors++;
      $display("BAD %0t no alarm event", $time);
      report_and_stop();
    end
  endtask

  function automatic logic [31:0] rnd_time();
    int h, m, s;
    h = $urandom % 24;
    m = $urandom % 60;
    s = $urandom % 60;
    return {4'(h / 10), 4'(h % 10), 4'(m / 10), 4'(m % 10), 4'(s / 10), 4'(s % 10),
            8'($urandom % 255 + 1)};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0; ce = 1'b1; sys_rst = 1'b0; sys_unlock = 1'b0;
    ext_en = 1'b0; int_en = 1'b0; wr = 1'b0; rd = 1'b0;
    addr = 8'h00; wdata = 32'h0; alarm_time = '0; alarm_date_hit = 1'b0;
    n_errors = 0; n_checks = 0;
    tv = $urandom(78767);
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    alarm_time <= rcal_time_t'($urandom);
    alarm_date_hit <= 1'b0;
    rd32(`RCAL_OFS_CTRL, 32'h0, MC);
    rd32(`RCAL_OFS_ALRM, 32'h0, MA);
    rd32(`RCAL_OFS_TIME, 32'h0, '1);
    wr32(8'h0c, $urandom);
    rd32(8'h0c, 32'h0, '1);
    // on, unlock, ext source, clock out, pin enable; locked at first
    cv = {6'h0, 10'($urandom), 16'h8309};
    tv = rnd_time();
    wr32(`RCAL_OFS_CTRL, cv);
    wr32(`RCAL_OFS_TIME, tv);
    rd32(`RCAL_OFS_CTRL, cv & 32'hffff_7ff7, MC);
    rd32(`RCAL_OFS_TIME, 32'h0, '1);
    sys_unlock <= 1'b1;
    wr32(`RCAL_OFS_CTRL, cv & 32'hffff_7fff);
    sys_unlock <= 1'b0;
    wr32(`RCAL_OFS_CTRL, cv);
    wr32(`RCAL_OFS_TIME, tv);
    rd32(`RCAL_OFS_TIME, {tv[31:8], 8'h00}, '1);
    rd32(`RCAL_OFS_CTRL, cv, MC);
    ext_en <= 1'b1;
    idle(100);
    rd32(`RCAL_OFS_CTRL, cv | 32'h40, MC);
    idle(2);
    pin_chk(1'b1, ext_h[3]);
    pin_toggles();
    ext_en <= 1'b0;
    int_en <= 1'b1;
    idle(4100);
    rd32(`RCAL_OFS_CTRL, cv, MC);
    // crystal stopped: only the internal source can move the pin
    wr32(`RCAL_OFS_CTRL, cv & 32'hffff_f9ff);
    idle(1);
    pin_toggles();
    ext_en <= 1'b1;
    cv = (cv & 32'hffff_f9ff) | 32'h400;
    wr32(`RCAL_OFS_CTRL, cv);
    idle(4100);
    rd32(`RCAL_OFS_CTRL, cv, MC);
    for (int i = 0; i < 10; i++) begin
      am = {16'h0, 1'b0, 1'($urandom), 2'b10, 4'(i), 8'($urandom)};
      wr32(`RCAL_OFS_ALRM, am);
      rd32(`RCAL_OFS_ALRM, am, MA);
    end
    wr32(`RCAL_OFS_CTRL, cv & 32'hffff_fe7f);
    idle(3);
    pin_chk(1'b1, 1'b1);
    wr32(`RCAL_OFS_CTRL, (cv & 32'hffff_fe7f) | 32'h80);
    idle(3);
    pin_chk(1'b1, 1'b0);
    wr32(`RCAL_OFS_ALRM, 32'ha000);
    wr32(`RCAL_OFS_ALRM, 32'h8000);
    rd32(`RCAL_OFS_ALRM, 32'ha000, MA);
    wr32(`RCAL_OFS_ALRM, 32'h0);
    wr32(`RCAL_OFS_ALRM, 32'h0);
    rd32(`RCAL_OFS_ALRM, 32'h0, MA);
    // fast crystal so that one half second fits in the run
    cv = (cv & 32'hffff_f9ff) | 32'h240;
    osc_hp = 10;
    wr32(`RCAL_OFS_CTRL, cv);
    wr32(`RCAL_OFS_ALRM, 32'h8000);
    wr32(`RCAL_OFS_TIME, tv);
    evt_wait();
    rd32(`RCAL_OFS_ALRM, 32'h2000, MA);
    rd32(`RCAL_OFS_CTRL, cv | 32'h2, MC);
    wr32(`RCAL_OFS_TIME, tv);
    rd32(`RCAL_OFS_CTRL, cv, MC);
    chk(32'(n_evt), 32'h1, '1);
    wr32(`RCAL_OFS_CTRL, cv & 32'hffff_fffe);
    idle(3);
    pin_chk(1'b0, 1'b0);
    // drop the unlock while on, then try to turn off
    wr32(`RCAL_OFS_CTRL, cv & 32'hffff_fff7);
    wr32(`RCAL_OFS_CTRL, cv & 32'hffff_7ff7);
    rd32(`RCAL_OFS_CTRL, cv & 32'hffff_fff7, MC);
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    idle(1);
    rd32(`RCAL_OFS_CTRL, cv & 32'hffff_fff7, MC);
    idle(1);
    arst_n <= 1'b0;
    idle(3);
    arst_n <= 1'b1;
    rd32(`RCAL_OFS_CTRL, 32'h0, MC);
    idle(3);
    report_and_stop();
  end
endmodule
